/* logic/idle_wakeup_sequencer.v */
// idle entry and wake-up sequencer for cpu and clock domain
// Behaviour
// (R1) The cpu leaves idle only on hardware reset, external interrupt, rtc interrupt or usb event.
// (R2) With the oscillator off, any wake event restarts the oscillator and enables the usb pll.
// (R3) A wake event whose enable bit is clear leaves the cpu idle though the clocks restart.
// (R4) An enabled wake interrupt reaches the cpu only after oscillator stable and pll lock.
// (R5) An external wake line must stay low at least 3 cycles after the oscillator is stable.
// (R6) If the external line rises too early, only the clock domain wakes and the cpu stays idle.
// (R7) Software not using usb should put the usb module into idle after wake-up.
// (R8) In host-port mode the plain clock-domain idle request is refused.
// (R9) In host-port mode the domain idles only with host idle and clock-generator idle both set.
// (R10) External lines pass two flops and are detected only on the sample run 1-1-0-0-0; in S_OSC_OFF a low synchronised level alone starts the wake.
// (R11) Hardware reset wakes the device unconditionally through the normal reset sequence.
`timescale 1ns/10ps
`include "idle_wakeup_defines.vh"
module idle_wakeup_sequencer
(
  input wire clk,
  input wire reset_n,
  input wire [7:0] addr,
  input wire [15:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [15:0] rdata_r,
  input wire cpu_idle_req,
  input wire ext_int_n,
  input wire rtc_int,
  input wire usb_event,
  input wire osc_stable,
  input wire usb_pll_locked,
  output reg cpu_idle_r,
  output reg cpu_wake_r,
  output reg [2:0] wake_source_r,
  output reg clk_domain_idle_r,
  output reg osc_enable_r,
  output reg usb_pll_enable_r,
  output reg irq_r
);

  // one-hot states
  localparam [5:0] S_RUN = 6'h01;
  localparam [5:0] S_CPU_IDLE = 6'h02;
  localparam [5:0] S_OSC_OFF = 6'h04;
  localparam [5:0] S_WARMUP = 6'h08;
  localparam [5:0] S_CHECK = 6'h10;
  localparam [5:0] S_EXT_HOLD = 6'h20;

  reg [5:0] state_r;
  reg [5:0] state_nxt;
  reg [15:0] idle_control_reg;
  reg [15:0] bus_select_reg;
  reg [15:0] interrupt_enable_reg;
  reg [15:0] status_r;
  reg [15:0] status_nxt;
  reg [15:0] mask_r;
  reg [2:0] pending_r;
  reg [2:0] pending_nxt;
  reg [1:0] low_cnt_r;
  reg [1:0] low_cnt_nxt;
  reg cpu_wake_nxt;
  reg [2:0] wake_source_nxt;
  reg refused_ev;
  reg domain_woke_ev;

  wire [3:0] async_bus;
  wire [3:0] sync_bus;
  wire ext_line_sync;
  wire rtc_sync;
  wire usb_sync;
  wire clocks_ready;
  wire ext_detect;
  wire ext_level_low;
  wire [2:0] wake_now;
  wire [2:0] enables;
  wire host_port_mode;
  wire host_idle_bit;
  wire clock_gen_idle_bit;
  wire domain_idle_ok;
  wire osc_ready_sync;
  wire pll_ready_sync;
  wire status_rd;

  // pins from outside the clock domain pass two flops
  assign async_bus = {usb_pll_locked, osc_stable, usb_event, rtc_int};

  sync_2ff #(.WIDTH(4), .INIT(4'h0)) u_sync_misc
  (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(async_bus),
    .sync_out(sync_bus)
  );

  // external line idles high, so its synchroniser resets high
  sync_2ff #(.WIDTH(1), .INIT(1'b1)) u_sync_ext
  (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(ext_int_n),
    .sync_out(ext_line_sync)
  ); // [R10]

  ext_int_detect u_ext_detect
  (
    .clk(clk),
    .reset_n(reset_n),
    .line_sync(ext_line_sync),
    .detect_r(ext_detect)
  ); // [R10]

  assign rtc_sync = sync_bus[0];
  assign usb_sync = sync_bus[1];
  assign osc_ready_sync = sync_bus[2];
  assign pll_ready_sync = sync_bus[3];
  assign clocks_ready = osc_ready_sync & pll_ready_sync;
  assign ext_level_low = ~ext_line_sync;

  // the three interrupt wake sources in source-bit order
  assign wake_now = {usb_sync, rtc_sync, ext_detect}; // [R1]
  assign enables = interrupt_enable_reg[2:0];

  // idle permission for the clock domain
  assign host_port_mode = bus_select_reg[`HOST_PORT_MODE_BIT];
  assign host_idle_bit = bus_select_reg[`HOST_IDLE_BIT];
  assign clock_gen_idle_bit = idle_control_reg[`CLOCK_GEN_IDLE_BIT];
  assign domain_idle_ok = clock_gen_idle_bit & (~host_port_mode | host_idle_bit); // [R8] [R9]

  // sequencer next state
  always @*
  begin
    state_nxt = state_r;
    pending_nxt = pending_r;
    low_cnt_nxt = low_cnt_r;
    cpu_wake_nxt = 1'b0;
    wake_source_nxt = wake_source_r;
    refused_ev = 1'b0;
    domain_woke_ev = 1'b0;
    case (state_r)
      S_RUN:
      begin
        if (cpu_idle_req)
        begin
          if (domain_idle_ok)
          begin
            state_nxt = S_OSC_OFF;
          end
          else
          begin
            state_nxt = S_CPU_IDLE;
            refused_ev = clock_gen_idle_bit; // [R8]
          end
        end
      end
      S_CPU_IDLE:
      begin
        // clocks running: enabled sources wake at once, masked ones do not
        if ((wake_now & enables) != 3'h0)
        begin
          state_nxt = S_RUN;
          cpu_wake_nxt = 1'b1;
          wake_source_nxt = wake_now & enables; // [R1] [R3]
        end
      end
      S_OSC_OFF:
      begin
        // low level on the external line counts as an event while stopped
        if ((wake_now[2:1] != 2'h0) || ext_level_low)
        begin
          state_nxt = S_WARMUP;
          pending_nxt = {wake_now[2:1], ext_level_low}; // [R2]
        end
      end
      S_WARMUP:
      begin
        pending_nxt = pending_r | wake_now;
        if (clocks_ready)
        begin
          state_nxt = S_CHECK; // [R4]
          domain_woke_ev = 1'b1;
        end
      end
      S_CHECK:
      begin
        low_cnt_nxt = 2'h0;
        if ((pending_r[2:1] & enables[2:1]) != 2'h0)
        begin
          state_nxt = S_RUN;
          cpu_wake_nxt = 1'b1;
          wake_source_nxt = pending_r & enables & 3'h6; // [R4]
        end
        else if (pending_r[`SRC_EXT] & enables[`SRC_EXT])
        begin
          state_nxt = S_EXT_HOLD;
        end
        else
        begin
          state_nxt = S_CPU_IDLE; // [R3]
        end
      end
      S_EXT_HOLD:
      begin
        // line must stay low for the hold time after stability
        if (!ext_level_low)
        begin
          state_nxt = S_CPU_IDLE; // [R6]
        end
        else if (low_cnt_r == (`EXT_LOW_CYCLES - 2'h1))
        begin
          state_nxt = S_RUN;
          cpu_wake_nxt = 1'b1;
          wake_source_nxt = 3'h1; // [R5]
        end
        else
        begin
          low_cnt_nxt = low_cnt_r + 2'h1;
        end
      end
      default:
      begin
        state_nxt = S_RUN;
      end
    endcase
  end

  // sequencer registers and flop-driven control outputs
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= S_RUN; // [R11]
      pending_r <= 3'h0;
      low_cnt_r <= 2'h0;
      cpu_wake_r <= 1'b0;
      wake_source_r <= 3'h0;
      cpu_idle_r <= 1'b0;
      clk_domain_idle_r <= 1'b0;
      osc_enable_r <= 1'b1;
      usb_pll_enable_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      pending_r <= (state_nxt == S_RUN) ? 3'h0 : pending_nxt;
      low_cnt_r <= low_cnt_nxt;
      cpu_wake_r <= cpu_wake_nxt;
      wake_source_r <= wake_source_nxt;
      cpu_idle_r <= (state_nxt != S_RUN);
      clk_domain_idle_r <= (state_nxt == S_OSC_OFF);
      osc_enable_r <= (state_nxt != S_OSC_OFF); // [R2]
      usb_pll_enable_r <= (state_nxt != S_OSC_OFF); // [R2]
    end
  end

  // sticky status: events set, a read of the register clears, set wins
  always @*
  begin
    status_nxt = status_r;
    if (status_rd)
    begin
      status_nxt = 16'h0000;
    end
    // new wake sources add to the kept bits, so a same-cycle read loses nothing
    if (cpu_wake_nxt)
    begin
      status_nxt[`ST_EXT_WAKE] = status_nxt[`ST_EXT_WAKE] | wake_source_nxt[`SRC_EXT];
      status_nxt[`ST_RTC_WAKE] = status_nxt[`ST_RTC_WAKE] | wake_source_nxt[`SRC_RTC];
      status_nxt[`ST_USB_WAKE] = status_nxt[`ST_USB_WAKE] | wake_source_nxt[`SRC_USB];
      status_nxt[`ST_CPU_WOKE] = 1'b1;
    end
    if (refused_ev)
    begin
      status_nxt[`ST_IDLE_REFUSED] = 1'b1;
    end
    if (domain_woke_ev)
    begin
      status_nxt[`ST_DOMAIN_WOKE] = 1'b1;
    end
  end

  // true when this cycle reads the status register
  assign status_rd = rd_stb && (addr == `ADDR_STATUS);

  // software registers
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      idle_control_reg <= `RST_IDLE_CONTROL;
      bus_select_reg <= `RST_BUS_SELECT;
      interrupt_enable_reg <= `RST_INT_ENABLE;
      mask_r <= `RST_MASK;
      status_r <= `RST_STATUS;
    end
    else
    begin
      status_r <= status_nxt;
      if (wr_stb)
      begin
        case (addr)
          `ADDR_IDLE_CONTROL:
          begin
            idle_control_reg <= {15'h0000, wdata[`CLOCK_GEN_IDLE_BIT]};
          end
          `ADDR_BUS_SELECT:
          begin
            bus_select_reg <= {14'h0000, wdata[1:0]};
          end
          `ADDR_INT_ENABLE:
          begin
            interrupt_enable_reg <= {13'h0000, wdata[2:0]};
          end
          `ADDR_MASK:
          begin
            mask_r <= {10'h000, wdata[5:0]};
          end
          default:
          begin
            mask_r <= mask_r;
          end
        endcase
      end
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata_r <= 16'h0000;
      irq_r <= 1'b0;
    end
    else
    begin
      irq_r <= ((status_nxt & mask_r) != 16'h0000);
      if (rd_stb)
      begin
        case (addr)
          `ADDR_IDLE_CONTROL: rdata_r <= idle_control_reg;
          `ADDR_BUS_SELECT: rdata_r <= bus_select_reg;
          `ADDR_INT_ENABLE: rdata_r <= interrupt_enable_reg;
          `ADDR_STATUS: rdata_r <= status_r;
          `ADDR_MASK: rdata_r <= mask_r;
          `ADDR_STATE: rdata_r <= {10'h000, state_r};
          default: rdata_r <= 16'h0000;
        endcase
      end
      else
      begin
        rdata_r <= 16'h0000;
      end
    end
  end

endmodule

/* logic/idle_wakeup_defines.vh */
// constants for the idle wake-up sequencer
`ifndef IDLE_WAKEUP_DEFINES_VH
`define IDLE_WAKEUP_DEFINES_VH

// register offsets on the plain register port
`define ADDR_IDLE_CONTROL 8'h00
`define ADDR_BUS_SELECT 8'h04
`define ADDR_INT_ENABLE 8'h08
`define ADDR_STATUS 8'h0C
`define ADDR_MASK 8'h10
`define ADDR_STATE 8'h14

// field positions
`define CLOCK_GEN_IDLE_BIT 0
`define HOST_PORT_MODE_BIT 0
`define HOST_IDLE_BIT 1
`define SRC_EXT 0
`define SRC_RTC 1
`define SRC_USB 2
`define ST_EXT_WAKE 0
`define ST_RTC_WAKE 1
`define ST_USB_WAKE 2
`define ST_IDLE_REFUSED 3
`define ST_CPU_WOKE 4
`define ST_DOMAIN_WOKE 5

// reset values
`define RST_IDLE_CONTROL 16'h0000
`define RST_BUS_SELECT 16'h0000
`define RST_INT_ENABLE 16'h0000
`define RST_STATUS 16'h0000
`define RST_MASK 16'h0000

// timing and detection
`define EXT_LOW_CYCLES 2'h3
`define EXT_DETECT_PATTERN 5'h18

`endif

/* logic/sync_2ff.v */
// two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/10ps
module sync_2ff
#(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
)
(
  input wire clk,
  input wire reset_n,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;

  // first stage feeds only the second stage
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_r <= INIT;
      sync_out <= INIT;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

/* logic/ext_int_detect.v */
// sample pattern detector for one external interrupt line
`timescale 1ns/10ps
`include "idle_wakeup_defines.vh"
module ext_int_detect
(
  input wire clk,
  input wire reset_n,
  input wire line_sync,
  output reg detect_r
);

  reg [4:0] hist_r;

  // history of consecutive samples, oldest in the top bit
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hist_r <= 5'h1F;
      detect_r <= 1'b0;
    end
    else
    begin
      hist_r <= {hist_r[3:0], line_sync};
      detect_r <= ({hist_r[3:0], line_sync} == `EXT_DETECT_PATTERN); // [R10]
    end
  end

endmodule

/* test/idle_wakeup_props.sv */
// assertion checker for the idle wake-up sequencer
`timescale 1ns/10ps
module idle_wakeup_props
(
  input wire clk,
  input wire reset_n,
  input wire rd_stb,
  input wire [15:0] rdata_r,
  input wire cpu_idle_req,
  input wire osc_stable,
  input wire usb_pll_locked,
  input wire cpu_idle_r,
  input wire cpu_wake_r,
  input wire [2:0] wake_source_r,
  input wire clk_domain_idle_r,
  input wire osc_enable_r,
  input wire usb_pll_enable_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // one-cycle wake pulse to the cpu
  sequence s_pulse;
    cpu_wake_r ##1 !cpu_wake_r;
  endsequence
  // oscillator and pll both settled
  sequence s_settled;
    $past(osc_stable, 2) && $past(usb_pll_locked, 2);
  endsequence
  chk_wake_one_cycle: assert property (cpu_wake_r |-> s_pulse)
    else $error("wake pulse longer than one cycle");
  chk_wake_after_lock: assert property (cpu_wake_r |-> s_settled)
    else $error("wake before oscillator stable and pll lock");
  chk_wake_has_source: assert property (cpu_wake_r |-> wake_source_r != 3'h0)
    else $error("wake without a source");
  chk_wake_ends_idle: assert property (cpu_wake_r |-> !cpu_idle_r)
    else $error("cpu still idle on wake");
  chk_idle_exit_wake: assert property ($fell(cpu_idle_r) |-> cpu_wake_r)
    else $error("cpu left idle without wake");
  chk_idle_entry_req: assert property
    ($rose(cpu_idle_r) |-> $past(cpu_idle_req) || $past(cpu_idle_req, 2))
    else $error("idle entered without request");
  chk_domain_clocks_off: assert property
    (clk_domain_idle_r |-> cpu_idle_r && !osc_enable_r && !usb_pll_enable_r)
    else $error("domain idle with clocks on");
  chk_osc_off_only_idle: assert property (!osc_enable_r |-> clk_domain_idle_r)
    else $error("oscillator off outside domain idle");
  chk_rd_quiet: assert property (!$past(rd_stb) |-> rdata_r == 16'h0000)
    else $error("read data outside read cycle");
endmodule
bind idle_wakeup_sequencer idle_wakeup_props u_props (.clk(clk), .reset_n(reset_n),
  .rd_stb(rd_stb), .rdata_r(rdata_r), .cpu_idle_req(cpu_idle_req), .osc_stable(osc_stable),
  .usb_pll_locked(usb_pll_locked), .cpu_idle_r(cpu_idle_r), .cpu_wake_r(cpu_wake_r),
  .wake_source_r(wake_source_r), .clk_domain_idle_r(clk_domain_idle_r),
  .osc_enable_r(osc_enable_r), .usb_pll_enable_r(usb_pll_enable_r));

/* test/osc_pll_model.sv */
// oscillator and usb pll partner model
`timescale 1ns/10ps
module osc_pll_model
#(
  parameter STABLE_CYCLES = 10
)
(
  input wire clk,
  input wire osc_enable,
  input wire pll_enable,
  output reg osc_stable = 1'b0,
  output reg pll_locked = 1'b0
);
  integer osc_cnt = 0;
  integer pll_cnt = 0;
  // settle counters restart whenever an enable drops
  always @(posedge clk)
  begin
    // an unknown enable before reset counts as off, so the counters never go unknown
    osc_cnt <= (osc_enable === 1'b1) ? osc_cnt + 1 : 0;
    pll_cnt <= (pll_enable === 1'b1) ? pll_cnt + 1 : 0;
    osc_stable <= (osc_enable === 1'b1) && osc_cnt >= STABLE_CYCLES;
    pll_locked <= (pll_enable === 1'b1) && pll_cnt >= STABLE_CYCLES + 3;
  end
endmodule

/* test/idle_wakeup_sequencer_tb.sv */
// self-checking bench for the idle wake-up sequencer
`timescale 1ns/10ps
`include "idle_wakeup_defines.vh"
module idle_wakeup_sequencer_tb;
  reg clk = 1'b0;
  reg reset_n = 1'b0;
  reg [7:0] addr = 8'h00;
  reg [15:0] wdata = 16'h0000;
  reg wr_stb = 1'b0;
  reg rd_stb = 1'b0;
  reg cpu_idle_req = 1'b0;
  reg ext_int_n = 1'b1;
  reg rtc_int = 1'b0;
  reg usb_event = 1'b0;
  wire osc_stable;
  wire usb_pll_locked;
  wire [15:0] rdata_r;
  wire cpu_idle_r;
  wire cpu_wake_r;
  wire [2:0] wake_source_r;
  wire clk_domain_idle_r;
  wire osc_enable_r;
  wire usb_pll_enable_r;
  wire irq_r;
  wire [15:0] flags = {11'h000, irq_r, cpu_idle_r, clk_domain_idle_r, osc_enable_r,
    usb_pll_enable_r};
  integer miscompares = 0;
  integer n_tests = 0;
  integer i;
  integer exp_st;
  reg [31:0] lfsr_r = 32'hE1B6314A;

  idle_wakeup_sequencer dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_r(rdata_r), .cpu_idle_req(cpu_idle_req),
    .ext_int_n(ext_int_n), .rtc_int(rtc_int), .usb_event(usb_event),
    .osc_stable(osc_stable), .usb_pll_locked(usb_pll_locked), .cpu_idle_r(cpu_idle_r),
    .cpu_wake_r(cpu_wake_r), .wake_source_r(wake_source_r),
    .clk_domain_idle_r(clk_domain_idle_r), .osc_enable_r(osc_enable_r),
    .usb_pll_enable_r(usb_pll_enable_r), .irq_r(irq_r));
  osc_pll_model #(.STABLE_CYCLES(10)) osc (.clk(clk), .osc_enable(osc_enable_r),
    .pll_enable(usb_pll_enable_r), .osc_stable(osc_stable), .pll_locked(usb_pll_locked));

  // clock
  initial
  begin
    forever #5 clk = ~clk;
  end

  function [31:0] lfsr_next(input [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task end_sim;
  begin
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask

  task check(input [15:0] got, input [15:0] e);
  begin
    n_tests = n_tests + 1;
    if (got !== e)
    begin
      miscompares = miscompares + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, e);
    end
  end
  endtask

  // register port cycles
  task wr(input [7:0] a, input [15:0] d);
  begin
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  end
  endtask

  task rd(input [7:0] a, input [15:0] e);
  begin
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    check(rdata_r, e);
  end
  endtask

  task go_idle(input [15:0] e);
  begin
    @(posedge clk);
    cpu_idle_req <= 1'b1;
    @(posedge clk);
    cpu_idle_req <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(flags, e);
  end
  endtask

  // wake source s held active for n cycles
  task hold(input integer s, input integer n);
  begin
    @(posedge clk);
    if (s == 0) ext_int_n <= 1'b0;
    if (s == 1) rtc_int <= 1'b1;
    if (s == 2) usb_event <= 1'b1;
    repeat (n) @(posedge clk);
    ext_int_n <= 1'b1;
    rtc_int <= 1'b0;
    usb_event <= 1'b0; // usb left quiet after each wake
  end
  endtask

  task wait_wake(input [2:0] src, input [15:0] ef);
    integer k;
  begin
    k = 0;
    while (cpu_wake_r !== 1'b1 && k < 80)
    begin
      @(posedge clk);
      #1;
      k = k + 1;
    end
    check({15'h0000, cpu_wake_r}, 16'h0001);
    check({13'h0000, wake_source_r}, {13'h0000, src});
    check(flags, ef);
  end
  endtask

  // watchdog
  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares = miscompares + 1;
    end_sim;
  end

  initial
  begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (20) @(posedge clk);
    #1;
    check(flags, 16'h0003);
    for (i = 0; i < 7; i = i + 1)
      rd(8'(i * 4), (i == 5) ? 16'h0001 : 16'h0000);
    for (i = 0; i < 5; i = i + 1)
    begin
      lfsr_r = lfsr_next(lfsr_r);
      if (i != 3) wr(8'(i * 4), lfsr_r[15:0]);
      if (i != 3) rd(8'(i * 4), lfsr_r[15:0] & ((i == 0) ? 16'h0001 : (i == 1) ? 16'h0003
        : (i == 2) ? 16'h0007 : 16'h003F));
    end
    wr(`ADDR_BUS_SELECT, 16'h0000);
    wr(`ADDR_IDLE_CONTROL, 16'h0001);
    wr(`ADDR_INT_ENABLE, 16'h0007);
    wr(`ADDR_MASK, 16'h0000);
    // each source wakes from oscillator off
    for (i = 0; i < 3; i = i + 1)
    begin
      go_idle(16'h000C);
      lfsr_r = lfsr_next(lfsr_r);
      fork
        hold(i, 40 + lfsr_r[3:0]);
        wait_wake(3'(1 << i), 16'h0003);
      join
    end
    // short external low wakes only the clocks
    go_idle(16'h000C);
    hold(0, 2);
    repeat (40) @(posedge clk);
    #1;
    check(flags, 16'h000B);
    fork
      hold(0, 12);
      wait_wake(3'h1, 16'h0003);
    join
    // masked source restarts clocks only
    wr(`ADDR_INT_ENABLE, 16'h0000);
    go_idle(16'h000C);
    hold(2, 40);
    #1;
    check(flags, 16'h000B);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    check(flags, 16'h0003);
    rd(`ADDR_STATUS, 16'h0000);
    // host-port mode refuses the domain idle, status raises irq
    wr(`ADDR_INT_ENABLE, 16'h0002);
    wr(`ADDR_BUS_SELECT, 16'h0001);
    wr(`ADDR_IDLE_CONTROL, 16'h0001);
    go_idle(16'h000B);
    wr(`ADDR_MASK, 16'h0008);
    repeat (2) @(posedge clk);
    #1;
    check(flags, 16'h001B);
    fork
      hold(1, 40);
      wait_wake(3'h2, 16'h0013);
    join
    exp_st = (1 << `ST_RTC_WAKE) | (1 << `ST_IDLE_REFUSED) | (1 << `ST_CPU_WOKE);
    rd(`ADDR_STATUS, exp_st[15:0]);
    repeat (2) @(posedge clk);
    #1;
    check(flags, 16'h0003);
    wr(`ADDR_BUS_SELECT, 16'h0003);
    go_idle(16'h000C);
    fork
      hold(1, 40);
      wait_wake(3'h2, 16'h0003);
    join
    end_sim;
  end
endmodule
